//--- kbd_cfg.svh
// Timing, command and reset constants for the keyboard matrix scanner
`ifndef KBD_CFG_SVH
`define KBD_CFG_SVH

// System clock and serial rate
`define CLK_HZ 10000000
`define CLK_NS 100
`define BAUD_HZ 62500
`define BIT_CYC (`CLK_HZ / `BAUD_HZ)

// Character layout
`define DATA_BITS 8
`define STOP_BITS 2

// Column dwell time before the sense lines are read
`define DWELL_NS 10000
`define DWELL_CYC ((`DWELL_NS + `CLK_NS - 1) / `CLK_NS)

// Host commands
`define CMD_LED 8'h10
`define CMD_QUERY 8'h30
`define CMD_BEEP 8'h20
`define CMD_CLICK 8'h21
`define CMD_REL_ON 8'h40
`define CMD_REL_OFF 8'h41

// Reply and keycode constants
`define QUERY_RESP 8'h01
`define KEY_OFS 7'h02
`define KEY_LAST_IDX 7'h7D

// Sound generator bytes
`define BEEP_ATT 8'h90
`define BEEP_FREQ 8'h8A
`define CLICK_ATT 8'h90
`define CLICK_FREQ 8'h8F

// Reset values
`define LED_DARK 6'h3F
`define SND_WRITES 2'h2

`endif

//--- kbd_pkg.sv
// Types shared by the keyboard matrix scanner modules
`default_nettype none
package kbd_pkg;
   typedef enum logic [4:0] {
      S_INIT = 5'h01,
      S_SCAN = 5'h02,
      S_CONFIRM = 5'h04,
      S_SEND = 5'h08,
      S_SWSCAN = 5'h10
   } scan_state_t;
   typedef enum logic [1:0] {
      SND_SILENT = 2'h0,
      SND_BEEP = 2'h1,
      SND_CLICK = 2'h2
   } snd_kind_t;
endpackage
`default_nettype wire

//--- kbd_uart_if.sv
// Byte carrier between the scanner core and its serial port
`timescale 1ns/10ps
`default_nettype none
interface kbd_uart_if;
   logic tx_start;
   logic [7:0] tx_data;
   logic tx_busy;
   logic tx_done;
   logic tx_line;
   logic rx_valid;
   logic [7:0] rx_data;
   modport core(output tx_start, tx_data, input tx_busy, tx_done, tx_line, rx_valid, rx_data);
   modport uart(input tx_start, tx_data, output tx_busy, tx_done, tx_line, rx_valid, rx_data);
endinterface
`default_nettype wire

//--- kbd_uart.sv
// Full-duplex serial port: 1 start, 8 data LSB first, 2 stop, no parity
`timescale 1ns/10ps
`default_nettype none
`include "kbd_cfg.svh"
module kbd_uart
   import kbd_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Receive line, already synchronised
   input wire logic rxd_i,
   // Core side
   kbd_uart_if.uart u
);
   localparam logic [7:0] BIT_LAST = 8'(`BIT_CYC - 1);
   localparam logic [7:0] HALF = 8'(`BIT_CYC / 2 - 1);
   localparam logic [3:0] TX_BITS = 4'(1 + `DATA_BITS + `STOP_BITS);
   localparam logic [3:0] RX_BITS = 4'(`DATA_BITS + 2);
   localparam int START_LAST = `BIT_CYC - 1;

   logic [10:0] tx_sh_reg, tx_sh_next;
   logic [3:0] tx_cnt_reg, tx_cnt_next;
   logic [7:0] tx_div_reg, tx_div_next;
   logic tx_line_reg, tx_line_next;
   logic tx_done_reg, tx_done_next;
   logic [3:0] rx_cnt_reg, rx_cnt_next;
   logic [7:0] rx_div_reg, rx_div_next;
   logic [7:0] rx_sh_reg, rx_sh_next;
   logic rx_valid_reg, rx_valid_next;

   // Transmit shifter; bit period from the clock divider
   always_comb begin
      tx_sh_next = tx_sh_reg;
      tx_cnt_next = tx_cnt_reg;
      tx_div_next = tx_div_reg;
      tx_line_next = tx_line_reg;
      tx_done_next = 1'b0;
      if (tx_cnt_reg == 4'h0) begin
         if (u.tx_start) begin
            tx_sh_next = {2'b11, u.tx_data, 1'b0};
            tx_cnt_next = TX_BITS;
            tx_div_next = 8'h00;
            tx_line_next = 1'b0;
         end
      end else if (tx_div_reg == BIT_LAST) begin
         tx_div_next = 8'h00;
         tx_sh_next = {1'b1, tx_sh_reg[10:1]};
         tx_cnt_next = tx_cnt_reg - 4'h1;
         if (tx_cnt_reg == 4'h1) begin
            tx_line_next = 1'b1;
            tx_done_next = 1'b1;
         end else begin
            tx_line_next = tx_sh_reg[1];
         end
      end else begin
         tx_div_next = tx_div_reg + 8'h01;
      end
   end

   // Receiver samples mid-bit; only the first stop bit is checked
   always_comb begin
      rx_cnt_next = rx_cnt_reg;
      rx_div_next = rx_div_reg;
      rx_sh_next = rx_sh_reg;
      rx_valid_next = 1'b0;
      if (rx_cnt_reg == 4'h0) begin
         if (!rxd_i) begin
            rx_cnt_next = RX_BITS;
            rx_div_next = HALF;
         end
      end else if (rx_div_reg != 8'h00) begin
         rx_div_next = rx_div_reg - 8'h01;
      end else begin
         rx_div_next = BIT_LAST;
         rx_cnt_next = rx_cnt_reg - 4'h1;
         if (rx_cnt_reg == RX_BITS) begin
            if (rxd_i) rx_cnt_next = 4'h0; // Glitch, not a start bit
         end else if (rx_cnt_reg == 4'h1) begin
            rx_valid_next = rxd_i;
         end else begin
            rx_sh_next = {rxd_i, rx_sh_reg[7:1]};
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_sh_reg <= 11'h7FF;
         tx_cnt_reg <= 4'h0;
         tx_div_reg <= 8'h00;
         tx_line_reg <= 1'b1;
         tx_done_reg <= 1'b0;
         rx_cnt_reg <= 4'h0;
         rx_div_reg <= 8'h00;
         rx_sh_reg <= 8'h00;
         rx_valid_reg <= 1'b0;
      end else begin
         tx_sh_reg <= tx_sh_next;
         tx_cnt_reg <= tx_cnt_next;
         tx_div_reg <= tx_div_next;
         tx_line_reg <= tx_line_next;
         tx_done_reg <= tx_done_next;
         rx_cnt_reg <= rx_cnt_next;
         rx_div_reg <= rx_div_next;
         rx_sh_reg <= rx_sh_next;
         rx_valid_reg <= rx_valid_next;
      end
   end

   assign u.tx_busy = (tx_cnt_reg != 4'h0);
   assign u.tx_done = tx_done_reg;
   assign u.tx_line = tx_line_reg;
   assign u.rx_valid = rx_valid_reg;
   assign u.rx_data = rx_sh_reg;

   property p_start_bit;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (u.tx_start && !u.tx_busy) |=> !tx_line_reg ##START_LAST !tx_line_reg;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("start bit not one period low");

   property p_done_idle;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      tx_done_reg |-> (tx_line_reg && $past(tx_line_reg) && !u.tx_busy);
   endproperty
   a_done_idle: assert property (p_done_idle) else $error("done without stop level");
endmodule
`default_nettype wire

//--- kbd_scanner.sv
// Keyboard matrix scanner top: scan, confirm, keycode, host commands
// How it works
// - One local clock drives all logic
// - Serial rate fixed at 62.5 K after reset
// - Frames: start, eight data, two stop
// - Reset silences sound and darkens all LEDs
// - Matrix is 16 columns by 8 rows
// - Three-bit counter plus bank select strobes columns
// - After init, scan the matrix continuously
// - Press accepted only if second read agrees
// - Column and row map to keycode table
// - Keycode framed and sent to host
// - Transmit completion resumes the column scan
// - Closed switch sets its setting bit
// - Open switch records no closure
// - Switch scan follows every matrix pass
// - Query returns the stored switch settings
// - Received commands decoded and dispatched
// - LED data byte loads the LED latch
// - LED outputs low means lit
// - Beep or click writes attenuation, frequency
// - Data bits go least significant first
// - Release code is press code plus 80
// - Query reply starts with byte 01
`timescale 1ns/10ps
`default_nettype none
`include "kbd_cfg.svh"
module kbd_scanner
   import kbd_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // Matrix sense rows and switch sense, asynchronous
   input wire logic [7:0] sense_i,
   input wire logic switch_hit_i,
   // Serial link
   input wire logic rxd_i,
   output logic txd_o,
   // Column strobes, active low
   output logic [15:0] col_strobe_n_o,
   // LED latch, active low
   output logic [5:0] led_n_o,
   // Sound generator write port
   output logic [7:0] sound_data_o,
   output logic sound_we_o
);
   localparam logic [6:0] DWELL_LAST = 7'(`DWELL_CYC - 1);

   kbd_uart_if u ();

   logic rst_meta_reg, rst_n;
   logic [7:0] sense_m_reg, sense_s;
   logic sw_m_reg, switch_s;
   logic rxd_m_reg, rxd_s;

   scan_state_t state_reg, state_next;
   logic [3:0] col_reg, col_next;
   logic [6:0] dwell_reg, dwell_next;
   logic [2:0] row_reg, row_next;
   logic level_reg, level_next;
   logic [7:0] key_down_reg [16];
   logic [7:0] key_down_next [16];
   logic [15:0] sw_reg, sw_next;
   logic [1:0] reply_reg, reply_next;
   logic expect_led_reg, expect_led_next;
   logic rel_en_reg, rel_en_next;
   logic [5:0] led_n_reg, led_n_next;
   logic [1:0] snd_cnt_reg, snd_cnt_next;
   snd_kind_t snd_kind_reg, snd_kind_next;
   logic snd_we_reg, snd_we_next;
   logic [7:0] snd_data_reg, snd_data_next;
   logic tx_start_reg, tx_start_next;
   logic [7:0] tx_data_reg, tx_data_next;
   logic sent_reg, sent_next;
   logic [15:0] strobe_n_reg, strobe_n_next;
   logic dwell_end;
   logic [3:0] hit;
   logic [7:0] code;
   logic key_chg;

   // One strobe per column; bit 3 picks the decoder bank
   function automatic logic [15:0] col_decode(input logic [3:0] c);
      logic [7:0] bank;
      bank = 8'h01 << c[2:0];
      col_decode = c[3] ? {bank, 8'h00} : {8'h00, bank};
   endfunction

   // Lowest row that differs from the remembered state
   function automatic logic [3:0] first_set(input logic [7:0] v);
      first_set = 4'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) first_set = {1'b1, 3'(i)};
      end
   endfunction

   // Position to keycode; codes 00 and 01 are never produced
   function automatic logic [7:0] key_lookup(input logic [3:0] c, input logic [2:0] r);
      logic [6:0] idx;
      idx = {c, r};
      key_lookup = {(idx <= `KEY_LAST_IDX), idx + `KEY_OFS};
   endfunction

   // Stored sound bytes: attenuation first, then frequency
   function automatic logic [7:0] snd_byte(input snd_kind_t k, input logic [1:0] n);
      case (k)
         SND_BEEP: snd_byte = n[1] ? `BEEP_ATT : `BEEP_FREQ;
         SND_CLICK: snd_byte = n[1] ? `CLICK_ATT : `CLICK_FREQ;
         default: snd_byte = 8'h00;
      endcase
   endfunction

   // Query reply bytes, counted down from three
   function automatic logic [7:0] reply_byte(input logic [1:0] n, input logic [15:0] s);
      case (n)
         2'h3: reply_byte = `QUERY_RESP;
         2'h2: reply_byte = s[7:0];
         default: reply_byte = s[15:8];
      endcase
   endfunction

   // Reset release and input synchronisers
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         sense_m_reg <= 8'h00;
         sense_s <= 8'h00;
         sw_m_reg <= 1'b0;
         switch_s <= 1'b0;
         rxd_m_reg <= 1'b1;
         rxd_s <= 1'b1;
      end else begin
         sense_m_reg <= sense_i;
         sense_s <= sense_m_reg;
         sw_m_reg <= switch_hit_i;
         switch_s <= sw_m_reg;
         rxd_m_reg <= rxd_i;
         rxd_s <= rxd_m_reg;
      end
   end

   kbd_uart i_kbd_uart (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .rxd_i(rxd_s),
      .u(u)
   );

   assign dwell_end = (dwell_reg == DWELL_LAST);
   assign hit = first_set(sense_s ^ key_down_reg[col_reg]);
   assign code = key_lookup(col_reg, row_reg);

   // Next state of scanner, command decoder and sound writer
   always_comb begin
      state_next = state_reg;
      col_next = col_reg;
      row_next = row_reg;
      level_next = level_reg;
      key_down_next = key_down_reg;
      sw_next = sw_reg;
      reply_next = reply_reg;
      expect_led_next = expect_led_reg;
      rel_en_next = rel_en_reg;
      led_n_next = led_n_reg;
      snd_kind_next = snd_kind_reg;
      tx_start_next = 1'b0;
      tx_data_next = tx_data_reg;
      sent_next = sent_reg;
      dwell_next = dwell_end ? 7'h00 : dwell_reg + 7'h01;
      strobe_n_next = 16'hFFFF;
      if (state_reg != S_INIT && state_reg != S_SEND) begin
         strobe_n_next = ~col_decode(col_reg);
      end
      // One sound byte per cycle while writes remain
      snd_we_next = (snd_cnt_reg != 2'h0);
      snd_data_next = snd_byte(snd_kind_reg, snd_cnt_reg);
      snd_cnt_next = (snd_cnt_reg != 2'h0) ? snd_cnt_reg - 2'h1 : 2'h0;
      case (state_reg)
         S_INIT: begin
            dwell_next = 7'h00;
            if (snd_cnt_reg == 2'h1) state_next = S_SCAN;
         end
         S_SCAN: begin
            if (dwell_end) begin
               if (reply_reg != 2'h0) begin
                  tx_data_next = reply_byte(reply_reg, sw_reg);
                  reply_next = reply_reg - 2'h1;
                  state_next = S_SEND;
               end else if (hit[3]) begin
                  row_next = hit[2:0];
                  level_next = sense_s[hit[2:0]];
                  state_next = S_CONFIRM;
               end else begin
                  col_next = col_reg + 4'h1;
                  if (col_reg == 4'hF) state_next = S_SWSCAN;
               end
            end
         end
         S_CONFIRM: begin
            if (dwell_end) begin
               state_next = S_SCAN;
               // Second read must match the first, else rescan this column
               if (sense_s[row_reg] == level_reg) begin
                  key_down_next[col_reg][row_reg] = level_reg;
                  if (code[7] && (level_reg || rel_en_reg)) begin
                     tx_data_next = {~level_reg, code[6:0]};
                     state_next = S_SEND;
                  end
               end
            end
         end
         S_SEND: begin
            dwell_next = 7'h00;
            if (!sent_reg && !u.tx_busy) begin
               tx_start_next = 1'b1;
               sent_next = 1'b1;
            end else if (sent_reg && u.tx_done) begin
               sent_next = 1'b0;
               state_next = S_SCAN;
            end
         end
         S_SWSCAN: begin
            if (dwell_end) begin
               sw_next[col_reg] = switch_s;
               col_next = col_reg + 4'h1;
               if (col_reg == 4'hF) state_next = S_SCAN;
            end
         end
         default: begin
            state_next = S_INIT;
         end
      endcase
      // Host command dispatch; a later beep or click overrides pending sound
      if (u.rx_valid) begin
         if (expect_led_reg) begin
            led_n_next = ~u.rx_data[5:0];
            expect_led_next = 1'b0;
         end else begin
            case (u.rx_data)
               `CMD_LED: expect_led_next = 1'b1;
               `CMD_QUERY: reply_next = 2'h3;
               `CMD_BEEP: begin
                  snd_kind_next = SND_BEEP;
                  snd_cnt_next = `SND_WRITES;
               end
               `CMD_CLICK: begin
                  snd_kind_next = SND_CLICK;
                  snd_cnt_next = `SND_WRITES;
               end
               `CMD_REL_ON: rel_en_next = 1'b1;
               `CMD_REL_OFF: rel_en_next = 1'b0;
               default: expect_led_next = 1'b0; // Unknown byte ignored
            endcase
         end
      end
   end

   // Registers; reset writes silence and darkens the LEDs
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= S_INIT;
         col_reg <= 4'h0;
         dwell_reg <= 7'h00;
         row_reg <= 3'h0;
         level_reg <= 1'b0;
         for (int i = 0; i < 16; i++) key_down_reg[i] <= 8'h00;
         sw_reg <= 16'h0000;
         reply_reg <= 2'h0;
         expect_led_reg <= 1'b0;
         rel_en_reg <= 1'b0;
         led_n_reg <= `LED_DARK;
         snd_cnt_reg <= `SND_WRITES;
         snd_kind_reg <= SND_SILENT;
         snd_we_reg <= 1'b0;
         snd_data_reg <= 8'h00;
         tx_start_reg <= 1'b0;
         tx_data_reg <= 8'h00;
         sent_reg <= 1'b0;
         strobe_n_reg <= 16'hFFFF;
      end else begin
         state_reg <= state_next;
         col_reg <= col_next;
         dwell_reg <= dwell_next;
         row_reg <= row_next;
         level_reg <= level_next;
         key_down_reg <= key_down_next;
         sw_reg <= sw_next;
         reply_reg <= reply_next;
         expect_led_reg <= expect_led_next;
         rel_en_reg <= rel_en_next;
         led_n_reg <= led_n_next;
         snd_cnt_reg <= snd_cnt_next;
         snd_kind_reg <= snd_kind_next;
         snd_we_reg <= snd_we_next;
         snd_data_reg <= snd_data_next;
         tx_start_reg <= tx_start_next;
         tx_data_reg <= tx_data_next;
         sent_reg <= sent_next;
         strobe_n_reg <= strobe_n_next;
      end
   end

   assign u.tx_start = tx_start_reg;
   assign u.tx_data = tx_data_reg;
   assign txd_o = u.tx_line;
   assign col_strobe_n_o = strobe_n_reg;
   assign led_n_o = led_n_reg;
   assign sound_data_o = snd_data_reg;
   assign sound_we_o = snd_we_reg;
   assign key_chg = (key_down_next != key_down_reg);

   property p_one_strobe;
      @(posedge clk_sys_i) disable iff (!rst_n)
      $countones(~strobe_n_reg) <= 1;
   endproperty
   a_one_strobe: assert property (p_one_strobe) else $error("several columns strobed");

   property p_confirm_only;
      @(posedge clk_sys_i) disable iff (!rst_n)
      key_chg |-> (state_reg == S_CONFIRM && dwell_end);
   endproperty
   a_confirm_only: assert property (p_confirm_only) else $error("key state changed unconfirmed");

   property p_led_load;
      @(posedge clk_sys_i) disable iff (!rst_n)
      (u.rx_valid && expect_led_reg) |=> (led_n_o == ~$past(u.rx_data[5:0]));
   endproperty
   a_led_load: assert property (p_led_load) else $error("LED latch not loaded inverted");

   property p_query;
      @(posedge clk_sys_i) disable iff (!rst_n)
      (u.rx_valid && !expect_led_reg && u.rx_data == `CMD_QUERY) |=> (reply_reg == 2'h3);
   endproperty
   a_query: assert property (p_query) else $error("query reply not armed");

   property p_no_busy_start;
      @(posedge clk_sys_i) disable iff (!rst_n)
      tx_start_reg |-> (!u.tx_busy && state_reg == S_SEND);
   endproperty
   a_no_busy_start: assert property (p_no_busy_start) else $error("send while busy");

   property p_resume;
      @(posedge clk_sys_i) disable iff (!rst_n)
      (state_reg == S_SEND && sent_reg && u.tx_done) |=> (state_reg == S_SCAN && !sent_reg);
   endproperty
   a_resume: assert property (p_resume) else $error("scan not resumed after send");

   property p_sw_after_pass;
      @(posedge clk_sys_i) disable iff (!rst_n)
      $rose(state_reg == S_SWSCAN) |-> ($past(col_reg) == 4'hF && col_reg == 4'h0);
   endproperty
   a_sw_after_pass: assert property (p_sw_after_pass) else $error("switch scan out of place");

   property p_beep;
      @(posedge clk_sys_i) disable iff (!rst_n)
      (u.rx_valid && !expect_led_reg && u.rx_data == `CMD_BEEP) |=> ##1
         (snd_we_reg && snd_data_reg == `BEEP_ATT) ##1 (snd_we_reg && snd_data_reg == `BEEP_FREQ);
   endproperty
   a_beep: assert property (p_beep) else $error("beep bytes wrong");

   property p_init_silent;
      @(posedge clk_sys_i) disable iff (!rst_n)
      (snd_we_reg && $past(snd_kind_reg) == SND_SILENT) |-> (snd_data_reg == 8'h00);
   endproperty
   a_init_silent: assert property (p_init_silent) else $error("init sound not zero");
endmodule
`default_nettype wire

//--- kbd_host_model.sv
// Host serial controller model: sends command bytes, collects reply bytes
`timescale 1ns/10ps
`default_nettype none
module kbd_host_model (
   // Clock
   input wire logic clk_sys_i,
   // Serial lines, both idle high
   input wire logic txd_i,
   output logic rxd_o
);
   localparam int BIT_CYC = 160;
   logic [7:0] rx_q [$];
   logic [7:0] rx_d;
   int frame_err;

   initial begin
      rxd_o = 1'b1;
      frame_err = 0;
   end

   // Start low, data LSB first, two stop highs, no parity
   task automatic send_byte(input logic [7:0] b);
      logic [10:0] f;
      f = {2'b11, b, 1'b0};
      @(negedge clk_sys_i);
      for (int i = 0; i < 11; i++) begin
         rxd_o <= f[i];
         repeat (BIT_CYC) @(negedge clk_sys_i);
      end
   endtask

   // Mid-bit sampling; every received byte is queued in rx_q until the bench pops it
   always begin
      @(negedge txd_i);
      repeat (BIT_CYC / 2) @(posedge clk_sys_i);
      if (txd_i === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_sys_i);
            rx_d[i] = txd_i;
         end
         repeat (2) begin
            repeat (BIT_CYC) @(posedge clk_sys_i);
            if (txd_i !== 1'b1) frame_err++;
         end
         rx_q.push_back(rx_d);
      end
   end
endmodule
`default_nettype wire

//--- kbd_scanner_tb.sv
// Self-checking bench for the keyboard matrix scanner
`timescale 1ns/10ps
`default_nettype none
`include "kbd_cfg.svh"
module kbd_scanner_tb;
   logic clk_sys_i, rstn_i, switch_hit_i, rxd, txd, sound_we;
   logic [7:0] sense_i, sound_data, b;
   logic [15:0] col_n, sw;
   logic [5:0] led_n;
   logic [7:0] keys [16];
   logic [7:0] snd_q [$];
   logic [8:0] strobed_v;
   logic [31:0] seed;
   logic [6:0] idx;
   int mismatches, num_checks, cyc;

   kbd_scanner i_kbd_scanner (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sense_i(sense_i),
      .switch_hit_i(switch_hit_i), .rxd_i(rxd), .txd_o(txd), .col_strobe_n_o(col_n),
      .led_n_o(led_n), .sound_data_o(sound_data), .sound_we_o(sound_we));
   kbd_host_model i_kbd_host_model (.clk_sys_i(clk_sys_i), .txd_i(txd), .rxd_o(rxd));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [7:0] key_code(input logic [6:0] i);
      return {1'b0, i + `KEY_OFS};
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (mismatches == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Bounded wait for one reply byte; X on timeout so the compare fails
   task automatic wait_byte(output logic [7:0] v);
      int n;
      n = 0;
      while (i_kbd_host_model.rx_q.size() == 0 && n < 8000) begin
         @(negedge clk_sys_i);
         n++;
      end
      v = (i_kbd_host_model.rx_q.size() != 0) ? i_kbd_host_model.rx_q.pop_front() : 8'hXX;
   endtask
   task automatic wait_col(input int k);
      int n;
      n = 0;
      while (col_n !== ~(16'h0001 << k) && n < 300) begin
         @(negedge clk_sys_i);
         n++;
      end
      check(col_n, ~(16'h0001 << k));
   endtask

   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   // Matrix and switch banks answer the strobed column only
   always @(negedge clk_sys_i) begin
      strobed_v = 9'h000;
      for (int c = 0; c < 16; c++) if (col_n[c] === 1'b0) strobed_v = {sw[c], keys[c]};
      {switch_hit_i, sense_i} <= strobed_v;
   end
   // Sound port writes, one byte per clock with sound_we high; sampled mid-cycle, clear of the launch edge
   always @(negedge clk_sys_i) if (sound_we === 1'b1) snd_q.push_back(sound_data);
   // Hang guard: longest run is well below this
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 90000) begin
         mismatches++;
         print_verdict();
      end
   end

   initial begin
      rstn_i = 1'b0;
      sense_i = 8'h00;
      switch_hit_i = 1'b0;
      sw = 16'h0000;
      seed = 32'h9C3C;
      foreach (keys[c]) keys[c] = 8'h00;
      repeat (3) @(negedge clk_sys_i);
      check(led_n, 6'h3F);
      check(col_n, 16'hFFFF);
      check(txd, 1'b1);
      repeat (3) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      repeat (10) @(negedge clk_sys_i);
      check(16'(snd_q.size()), 16'h0002);
      check(snd_q[0] | snd_q[1], 8'h00);
      for (int k = 0; k < 16; k++) wait_col(k);
      // Corner keys first, then random; release codes only while enabled
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         idx = (i == 0) ? 7'h00 : (i == 1) ? 7'h7D : 7'(seed % 126);
         if (i == 1) i_kbd_host_model.send_byte(`CMD_REL_ON);
         if (i == 3) i_kbd_host_model.send_byte(`CMD_REL_OFF);
         keys[idx[6:3]][idx[2:0]] = 1'b1;
         wait_byte(b);
         check(b, key_code(idx));
         keys[idx[6:3]][idx[2:0]] = 1'b0;
         if (i == 0 || i == 3) begin
            repeat (4000) @(negedge clk_sys_i);
            check(16'(i_kbd_host_model.rx_q.size()), 16'h0000);
         end else begin
            wait_byte(b);
            check(b, key_code(idx) | 8'h80);
         end
      end
      // LED byte in, active-low latch out
      for (int j = 0; j < 2; j++) begin
         seed = lfsr(seed);
         i_kbd_host_model.send_byte(`CMD_LED);
         i_kbd_host_model.send_byte(seed[7:0]);
         repeat (200) @(negedge clk_sys_i);
         check(led_n, seed[5:0] ^ 6'h3F);
      end
      // Beep then click: attenuation byte, then frequency byte
      for (int s = 0; s < 2; s++) begin
         snd_q.delete();
         i_kbd_host_model.send_byte(s ? `CMD_CLICK : `CMD_BEEP);
         repeat (20) @(negedge clk_sys_i);
         check(16'(snd_q.size()), 16'h0002);
         check(snd_q[0], s ? `CLICK_ATT : `BEEP_ATT);
         check(snd_q[1], s ? `CLICK_FREQ : `BEEP_FREQ);
      end
      // Second query flips every switch, so stale closures show up
      for (int q = 0; q < 2; q++) begin
         seed = lfsr(seed);
         sw = q ? ~sw : seed[15:0];
         repeat (6600) @(negedge clk_sys_i);
         i_kbd_host_model.send_byte(`CMD_QUERY);
         wait_byte(b);
         check(b, `QUERY_RESP);
         wait_byte(b);
         check(b, sw[7:0]);
         wait_byte(b);
         check(b, sw[15:8]);
      end
      check(16'(i_kbd_host_model.frame_err), 16'h0000);
      print_verdict();
   end

   initial begin
      mismatches = 0;
      num_checks = 0;
      cyc = 0;
   end
endmodule
`default_nettype wire
